// ==== esr_pkg.sv ====
// package: constants for the embedded synchronous ram block
package esr_pkg;
  localparam int unsigned ESR_TOTAL_BITS  = 4608;
  localparam int unsigned ESR_PHYS_W      = 36;
  localparam int unsigned ESR_PHYS_DEPTH  = 128;
  localparam int unsigned ESR_PHYS_AW     = 7;
  localparam int unsigned ESR_ADDR_W      = 12;
  localparam int unsigned ESR_LANES       = 4;
  localparam int unsigned ESR_HALF_W      = 18;
  localparam int unsigned ESR_LANE_W8     = 8;
  localparam int unsigned ESR_LANE_W9     = 9;
  localparam logic [3:0]  ESR_LANE_ALL    = 4'h f;
  localparam logic [35:0] ESR_DOUT_RST    = 36'h0_0000_0000;
  localparam logic [11:0] ESR_ADDR_RST    = 12'h000;

  // port width selector; parity widths mix only with parity widths
  typedef enum logic [3:0] {
    ESR_W1  = 4'h0,
    ESR_W2  = 4'h1,
    ESR_W4  = 4'h2,
    ESR_W8  = 4'h3,
    ESR_W16 = 4'h4,
    ESR_W32 = 4'h5,
    ESR_W9  = 4'h6,
    ESR_W18 = 4'h7,
    ESR_W36 = 4'h8
  } esr_width_e;

  typedef enum logic [1:0] {
    ESR_MODE_SINGLE = 2'h0,
    ESR_MODE_SDP    = 2'h1,
    ESR_MODE_PACKED = 2'h2
  } esr_mode_e;
endpackage : esr_pkg

// ==== esr_addr_reg.sv ====
// address input register with hold recirculation
`timescale 1ns/1ps
module esr_addr_reg
  import esr_pkg::*;
#(
  parameter int unsigned AW = 12
) (
  // clock
  input  wire logic          clk_sys,
  input  wire logic          clk_en,
  // address
  input  wire logic [AW-1:0] addr_in,
  input  wire logic          addr_hold,
  output logic      [AW-1:0] addr_q
);
  logic [AW-1:0] addr_nxt;

  // feedback mux keeps the old address while hold is high
  assign addr_nxt = addr_hold ? addr_q : addr_in;

  // no clear on input registers; power-up value is a don't care
  always_ff @(posedge clk_sys) begin
    if (clk_en) begin
      addr_q <= addr_nxt;
    end
  end

  a_hold_keeps_addr: assert property (@(posedge clk_sys)
    (clk_en && addr_hold) |=> addr_q == $past(addr_q)) else $error("address moved during hold");
endmodule : esr_addr_reg

// ==== esr_ram_block.sv ====
// embedded synchronous ram block: single-port, packed and simple dual-port
`timescale 1ns/1ps
module esr_ram_block
  import esr_pkg::*;
#(
  parameter esr_mode_e  MODE    = ESR_MODE_SDP,
  parameter esr_width_e WR_W    = ESR_W36,
  parameter esr_width_e RD_W    = ESR_W36,
  parameter bit         OUT_REG = 1'b1
) (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic        clk_en,
  // port A: write port (shared read/write in single-port)
  input  wire logic [11:0] addr_a,
  input  wire logic        addr_hold_a,
  input  wire logic [35:0] wdata_a,
  input  wire logic        wren_a,
  input  wire logic [3:0]  lane_en,
  // port B: read port (second memory in packed mode)
  input  wire logic [11:0] addr_b,
  input  wire logic        addr_hold_b,
  input  wire logic [17:0] wdata_b,
  input  wire logic        wren_b,
  input  wire logic        rden_b,
  // read data
  output logic      [35:0] rdata_a,
  output logic      [35:0] rdata_b
);
  // physical array: 128 rows of 36 bits = 4608 bits
  logic [35:0] mem_r [ESR_PHYS_DEPTH];

  logic [11:0] addr_a_q;
  logic [11:0] addr_b_q;
  logic [35:0] wdata_a_r;
  logic [17:0] wdata_b_r;
  logic        wren_a_r;
  logic        wren_b_r;
  logic        rden_b_r;
  logic [3:0]  lane_r;
  logic [35:0] rd_a_nxt;
  logic [35:0] rd_b_nxt;
  logic [35:0] flow_a_r;
  logic [35:0] flow_b_r;
  logic [35:0] out_a_r;
  logic [35:0] out_b_r;

  // mixed widths across the parity boundary are illegal
  function automatic bit esr_is_parity(input esr_width_e w);
    return (w == ESR_W9) || (w == ESR_W18) || (w == ESR_W36);
  endfunction : esr_is_parity

  // width in bits of a logical word
  function automatic int unsigned esr_bits(input esr_width_e w);
    unique case (w)
      ESR_W1:  return 1;
      ESR_W2:  return 2;
      ESR_W4:  return 4;
      ESR_W8:  return 8;
      ESR_W9:  return 9;
      ESR_W16: return 16;
      ESR_W18: return 18;
      ESR_W32: return 32;
      ESR_W36: return 36;
      default: return 36;
    endcase
  endfunction : esr_bits

  // logical words held in one 36-bit row (parity) or 32-bit row (plain)
  function automatic int unsigned esr_per_row(input esr_width_e w);
    return (esr_is_parity(w) ? ESR_PHYS_W : 32) / esr_bits(w);
  endfunction : esr_per_row

  // lane width: 9 for parity widths, 8 otherwise
  function automatic int unsigned esr_lane_w(input esr_width_e w);
    return esr_is_parity(w) ? ESR_LANE_W9 : ESR_LANE_W8;
  endfunction : esr_lane_w

  // per-bit write mask of a logical word placed at slot in the row
  function automatic logic [35:0] esr_wmask(input esr_width_e w, input logic [3:0] ln,
                                            input int unsigned slot);
    logic [35:0] m;
    int unsigned b;
    int unsigned lw;
    m  = '0;
    b  = esr_bits(w);
    lw = esr_lane_w(w);
    for (int i = 0; i < 36; i++) begin
      if (i < b) begin
        // narrow words: lane bit 0 is only a second write qualifier
        if (b <= ESR_LANE_W9) begin
          m[(slot*b + i) % 36] = ln[0];
        end else begin
          m[(slot*b + i) % 36] = ln[i / lw];
        end
      end
    end
    return m;
  endfunction : esr_wmask

  initial begin
    if (esr_is_parity(WR_W) != esr_is_parity(RD_W)) begin
      $error("mixed widths must share parity group");
    end
  end

  // input registers; only the address registers can hold
  esr_addr_reg #(.AW(ESR_ADDR_W)) u_addr_a (
    .clk_sys   (clk_sys),
    .clk_en    (clk_en),
    .addr_in   (addr_a),
    .addr_hold (addr_hold_a),
    .addr_q    (addr_a_q)
  );

  esr_addr_reg #(.AW(ESR_ADDR_W)) u_addr_b (
    .clk_sys   (clk_sys),
    .clk_en    (clk_en),
    .addr_in   (addr_b),
    .addr_hold (addr_hold_b),
    .addr_q    (addr_b_q)
  );

  // data, strobe and mask capture carry no clear of any kind
  always_ff @(posedge clk_sys) begin
    if (clk_en) begin
      wdata_a_r <= wdata_a;
      wdata_b_r <= wdata_b;
      wren_a_r  <= wren_a;
      wren_b_r  <= wren_b;
      rden_b_r  <= rden_b;
      lane_r    <= lane_en;
    end
  end

  // row/slot of a logical address for a given width
  function automatic logic [6:0] esr_row(input esr_width_e w, input logic [11:0] a);
    return 7'(a / esr_per_row(w));
  endfunction : esr_row

  function automatic int unsigned esr_slot(input esr_width_e w, input logic [11:0] a);
    return a % esr_per_row(w);
  endfunction : esr_slot

  // extract a logical word from a row
  function automatic logic [35:0] esr_pick(input esr_width_e w, input logic [35:0] row,
                                           input int unsigned slot);
    logic [35:0] v;
    v = '0;
    for (int i = 0; i < 36; i++) begin
      if (i < esr_bits(w)) begin
        v[i] = row[(slot*esr_bits(w) + i) % 36];
      end
    end
    return v;
  endfunction : esr_pick

  // place a logical word into row position
  function automatic logic [35:0] esr_place(input esr_width_e w, input logic [35:0] d,
                                            input int unsigned slot);
    logic [35:0] v;
    v = '0;
    for (int i = 0; i < 36; i++) begin
      if (i < esr_bits(w)) begin
        v[(slot*esr_bits(w) + i) % 36] = d[i];
      end
    end
    return v;
  endfunction : esr_place

  // packed mode: port A owns rows 0..63, port B rows 64..127, each x18 max
  logic [6:0]  row_a;
  logic [6:0]  row_b;
  logic [35:0] wm_a;
  logic [35:0] wm_b;
  logic [35:0] wv_a;
  logic [35:0] wv_b;

  always_comb begin
    if (MODE == ESR_MODE_PACKED) begin
      row_a = esr_row(WR_W, addr_a_q) & 7'h3f;
      row_b = esr_row(WR_W, addr_b_q) | 7'h40;
      wm_a  = esr_wmask(WR_W, {2'b00, lane_r[1:0]}, esr_slot(WR_W, addr_a_q));
      wm_b  = esr_wmask(WR_W, {2'b00, lane_r[3:2]}, esr_slot(WR_W, addr_b_q));
    end else begin
      row_a = esr_row(WR_W, addr_a_q);
      row_b = esr_row(RD_W, addr_b_q);
      wm_a  = esr_wmask(WR_W, lane_r, esr_slot(WR_W, addr_a_q));
      wm_b  = '0;
    end
    wv_a = esr_place(WR_W, wdata_a_r, esr_slot(WR_W, addr_a_q));
    wv_b = esr_place(WR_W, {18'h0_0000, wdata_b_r}, esr_slot(WR_W, addr_b_q));
  end

  // write at the edge after capture; masked lanes keep old bits
  always_ff @(posedge clk_sys) begin
    if (clk_en && wren_a_r) begin
      mem_r[row_a] <= (mem_r[row_a] & ~wm_a) | (wv_a & wm_a);
    end
    if (clk_en && wren_b_r && MODE == ESR_MODE_PACKED) begin
      mem_r[row_b] <= (mem_r[row_b] & ~wm_b) | (wv_b & wm_b);
    end
  end

  // read paths: single/packed ports show written data, masked lanes unknown
  always_comb begin
    rd_a_nxt = esr_pick(RD_W, mem_r[row_a], esr_slot(RD_W, addr_a_q));
    if (MODE != ESR_MODE_SDP && wren_a_r) begin
      rd_a_nxt = (esr_pick(WR_W, wv_a, esr_slot(WR_W, addr_a_q)) &
                  esr_pick(WR_W, wm_a, esr_slot(WR_W, addr_a_q))) |
                 ({36{1'bx}} & ~esr_pick(WR_W, wm_a, esr_slot(WR_W, addr_a_q)));
    end
    // sdp read samples the array before this edge's write: old data
    rd_b_nxt = esr_pick(RD_W, mem_r[row_b], esr_slot(RD_W, addr_b_q));
    if (MODE == ESR_MODE_PACKED && wren_b_r) begin
      rd_b_nxt = (esr_pick(WR_W, wv_b, esr_slot(WR_W, addr_b_q)) &
                  esr_pick(WR_W, wm_b, esr_slot(WR_W, addr_b_q))) |
                 ({36{1'bx}} & ~esr_pick(WR_W, wm_b, esr_slot(WR_W, addr_b_q)));
    end
  end

  // flow-through stage: array output latch, cleared by async rst_b
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      flow_a_r <= ESR_DOUT_RST;
      flow_b_r <= ESR_DOUT_RST;
    end else if (clk_en) begin
      flow_a_r <= rd_a_nxt;
      if (MODE != ESR_MODE_SDP || rden_b_r) begin
        flow_b_r <= rd_b_nxt;
      end
    end
  end

  // optional pipeline register, async clear like the flow-through stage
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      out_a_r <= ESR_DOUT_RST;
      out_b_r <= ESR_DOUT_RST;
    end else if (clk_en) begin
      out_a_r <= flow_a_r;
      out_b_r <= flow_b_r;
    end
  end

  // async clear is seen at once on the outputs in either configuration
  always_comb begin
    if (!rst_b) begin
      rdata_a = ESR_DOUT_RST;
      rdata_b = ESR_DOUT_RST;
    end else begin
      rdata_a = OUT_REG ? out_a_r : flow_a_r;
      rdata_b = OUT_REG ? out_b_r : flow_b_r;
    end
  end

  // checks
  sequence s_rd_off;
    (clk_en && !rden_b_r);
  endsequence

  a_rden_holds: assert property (@(posedge clk_sys) disable iff (!rst_b)
    ((MODE == ESR_MODE_SDP) and s_rd_off) |=> flow_b_r === $past(flow_b_r))
    else $error("read output moved with read enable low");
  a_freeze_en: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !clk_en |=> (flow_a_r === $past(flow_a_r)) && (lane_r === $past(lane_r)))
    else $error("state moved with clock enable low");
  a_mask_keeps: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (clk_en && wren_a_r && !wren_b_r) |=>
      ((mem_r[$past(row_a)] & ~$past(wm_a)) == ($past(mem_r[row_a]) & ~$past(wm_a))))
    else $error("masked lane changed");
  a_write_lands: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (clk_en && wren_a_r && !(wren_b_r && MODE == ESR_MODE_PACKED)) |=>
      ((mem_r[$past(row_a)] & $past(wm_a)) == ($past(wv_a) & $past(wm_a))))
    else $error("enabled lane not written");
  a_lane_capture: assert property (@(posedge clk_sys) disable iff (!rst_b)
    clk_en |=> lane_r == $past(lane_en)) else $error("mask not captured");
  a_flow_sp: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (MODE == ESR_MODE_SINGLE && clk_en && wren_a_r && lane_r == ESR_LANE_ALL) |=>
      flow_a_r == esr_pick(WR_W, $past(wv_a), esr_slot(WR_W, $past(addr_a_q))))
    else $error("write data not flowed through");
  a_old_data: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (MODE == ESR_MODE_SDP && clk_en && rden_b_r && wren_a_r) |=>
      flow_b_r === $past(rd_b_nxt)) else $error("sdp read not old data");
  a_pipe_lag: assert property (@(posedge clk_sys) disable iff (!rst_b)
    clk_en |=> out_a_r === $past(flow_a_r)) else $error("pipeline stage lost");
endmodule : esr_ram_block

// ==== esr_user_drv.sv ====
// user-side logic model that presents requests to the ram block after each edge
`timescale 1ns/1ps
module esr_user_drv
  import esr_pkg::*;
(
  // clock
  input  wire logic        clk_sys,
  // requests from the bench
  input  wire logic        req_ce,
  input  wire logic [11:0] req_aa,
  input  wire logic        req_ha,
  input  wire logic [35:0] req_wd,
  input  wire logic        req_we,
  input  wire logic [3:0]  req_le,
  input  wire logic [11:0] req_ab,
  input  wire logic        req_hb,
  input  wire logic        req_rd,
  // ram block inputs
  output logic             clk_en,
  output logic      [11:0] addr_a,
  output logic             addr_hold_a,
  output logic      [35:0] wdata_a,
  output logic             wren_a,
  output logic      [3:0]  lane_en,
  output logic      [11:0] addr_b,
  output logic             addr_hold_b,
  output logic             rden_b
);
  // idle user logic leaves mask high and holds low
  initial begin
    clk_en      = 1'b1;
    addr_a      = '0;
    addr_hold_a = 1'b0;
    wdata_a     = '0;
    wren_a      = 1'b0;
    lane_en     = ESR_LANE_ALL;
    addr_b      = '0;
    addr_hold_b = 1'b0;
    rden_b      = 1'b0;
  end

  // registered-style launch: same small delay after every rising edge
  always @(posedge clk_sys) begin
    #1;
    clk_en      <= req_ce;
    addr_a      <= req_aa;
    addr_hold_a <= req_ha;
    wdata_a     <= req_wd;
    wren_a      <= req_we;
    lane_en     <= req_le;
    addr_b      <= req_ab;
    addr_hold_b <= req_hb;
    rden_b      <= req_rd;
  end
endmodule : esr_user_drv

// ==== test_esr_ram_block.sv ====
// self-checking bench for the ram block in simple dual-port x36 mode
`timescale 1ns/1ps
module test_esr_ram_block
  import esr_pkg::*;
;
  logic        clk_sys, rst_b;
  logic        q_ce, q_ha, q_we, q_hb, q_rd;
  logic [11:0] q_aa, q_ab;
  logic [35:0] q_wd;
  logic [3:0]  q_le;
  logic        clk_en, addr_hold_a, wren_a, addr_hold_b, rden_b;
  logic [11:0] addr_a, addr_b;
  logic [35:0] wdata_a, rdata_a, rdata_b;
  logic [3:0]  lane_en;
  // reference model state
  logic [35:0] mem_m [128];
  bit          mwv [128];
  logic [35:0] s1, s2, s3;
  bit          v1, v2, v3;
  logic [6:0]  wa_m, ra_m;
  int          n_mismatch, total_checks;

  esr_user_drv u_esr_user_drv (
    .clk_sys(clk_sys), .req_ce(q_ce), .req_aa(q_aa), .req_ha(q_ha), .req_wd(q_wd),
    .req_we(q_we), .req_le(q_le), .req_ab(q_ab), .req_hb(q_hb), .req_rd(q_rd),
    .clk_en(clk_en), .addr_a(addr_a), .addr_hold_a(addr_hold_a), .wdata_a(wdata_a),
    .wren_a(wren_a), .lane_en(lane_en), .addr_b(addr_b), .addr_hold_b(addr_hold_b),
    .rden_b(rden_b));

  esr_ram_block #(.MODE(ESR_MODE_SDP), .WR_W(ESR_W36), .RD_W(ESR_W36), .OUT_REG(1'b1))
  u_esr_ram_block (
    .clk_sys(clk_sys), .rst_b(rst_b), .clk_en(clk_en), .addr_a(addr_a),
    .addr_hold_a(addr_hold_a), .wdata_a(wdata_a), .wren_a(wren_a), .lane_en(lane_en),
    .addr_b(addr_b), .addr_hold_b(addr_hold_b), .wdata_b(18'h0_0000), .wren_b(1'b0),
    .rden_b(rden_b), .rdata_a(rdata_a), .rdata_b(rdata_b));

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic chk(input string nm, input logic [35:0] ex, input logic [35:0] got);
    total_checks++;
    if (got !== ex) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : wrap_up

  // model stages: s1 flow after next edge, s2 flow now, s3 output now
  // read sees the array before this edge's write
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s3 = '0;
      v3 = 1'b1;
      s2 = '0;
      v2 = 1'b1;
      v1 = 1'b0;
    end else if (clk_en) begin
      s3 = s2;
      v3 = v2;
      s2 = s1;
      v2 = v1;
      if (!addr_hold_a) wa_m = addr_a[6:0];
      if (!addr_hold_b) ra_m = addr_b[6:0];
      if (rden_b) begin
        s1 = mem_m[ra_m];
        v1 = mwv[ra_m];
      end
      if (wren_a) begin
        for (int n = 0; n < 4; n++) if (lane_en[n]) mem_m[wa_m][n*9 +: 9] = wdata_a[n*9 +: 9];
        if (lane_en == ESR_LANE_ALL) mwv[wa_m] = 1'b1;
      end
    end
  end

  // rows never fully written hold unknown data and are not compared
  always @(negedge clk_sys) if (v3) chk("rdata_b", s3, rdata_b);

  task automatic rnd(input int cnt, input bit fill, input bit hz, input bit cz);
    for (int i = 0; i < cnt; i++) begin
      @(posedge clk_sys);
      q_we = fill | 1'($urandom);
      q_le = fill ? ESR_LANE_ALL : 4'($urandom);
      q_wd = 36'({$urandom, $urandom});
      q_aa = fill ? 12'(i) : 12'($urandom % 16);
      q_ab = ($urandom % 4 == 0) ? q_aa : 12'($urandom % 16);
      q_rd = fill | 1'($urandom);
      q_ha = hz & 1'($urandom);
      q_hb = hz & 1'($urandom);
      q_ce = !cz | 1'($urandom);
    end
  endtask : rnd

  initial begin
    rst_b = 1'b0;
    {q_ce, q_ha, q_we, q_hb, q_rd} = 5'b10000;
    q_aa = '0;
    q_ab = '0;
    q_wd = '0;
    q_le = ESR_LANE_ALL;
    void'($urandom(32'ha2d1_0354));
    repeat (6) @(posedge clk_sys);
    #1 rst_b = 1'b1;
    rnd(16, 1'b1, 1'b0, 1'b0);
    rnd(16, 1'b1, 1'b0, 1'b0);
    $display("test fill done");
    rnd(300, 1'b0, 1'b0, 1'b0);
    $display("test masked traffic done");
    rnd(100, 1'b0, 1'b1, 1'b0);
    $display("test address hold done");
    rnd(100, 1'b0, 1'b0, 1'b1);
    $display("test clock enable done");
    @(posedge clk_sys);
    #1 rst_b = 1'b0;
    #1 chk("rdata_b in clear", '0, rdata_b);
    chk("rdata_a in clear", '0, rdata_a);
    repeat (2) @(posedge clk_sys);
    #1 rst_b = 1'b1;
    rnd(50, 1'b0, 1'b1, 1'b1);
    $display("test mid-run clear done");
    q_rd = 1'b0;
    repeat (4) @(posedge clk_sys);
    wrap_up();
  end

  initial begin
    #4000000;
    n_mismatch++;
    wrap_up();
  end
endmodule : test_esr_ram_block
